// *** cns_pkg.sv ***
package cns_pkg;

  // frame identifier bases, node number added on top
  localparam logic [10:0] REQ_ID_BASE = 11'h600;
  localparam logic [10:0] RSP_ID_BASE = 11'h580;

  // command bytes
  localparam logic [7:0] CMD_RD_REQ = 8'h40;
  localparam logic [7:0] CMD_WR_1 = 8'h2f;
  localparam logic [7:0] CMD_WR_2 = 8'h2b;
  localparam logic [7:0] CMD_WR_4 = 8'h23;
  localparam logic [7:0] CMD_RD_1 = 8'h4f;
  localparam logic [7:0] CMD_RD_2 = 8'h4b;
  localparam logic [7:0] CMD_RD_4 = 8'h43;
  localparam logic [7:0] CMD_WR_ACK = 8'h60;
  localparam logic [7:0] CMD_ERROR = 8'h80;

  // bit-rate setting codes and the matching rate in kbit/s
  localparam logic [7:0] RATE_CODE_50K = 8'h05;
  localparam logic [7:0] RATE_CODE_125K = 8'h0c;
  localparam logic [7:0] RATE_CODE_250K = 8'h19;
  localparam logic [7:0] RATE_CODE_500K = 8'h32;
  localparam logic [7:0] RATE_CODE_1M = 8'h64;
  localparam logic [10:0] RATE_KBPS_DEFAULT = 11'd500;

  // error codes used by this front end
  localparam logic [31:0] ERR_LEN_MISMATCH = 32'h06070010;
  localparam logic [31:0] ERR_ACCESS = 32'h06010000;

  // reply timing: reply leaves this many cycles after the object answer
  localparam int RSP_LATENCY_CYC = 1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_SEND = 3'b100
  } cns_state_type;

  // one bus message: identifier, length count, up to 8 bytes from byte 0
  typedef struct packed {
    logic [10:0] ident;
    logic [3:0] len;
    logic [7:0][7:0] data;
  } cns_frame_type;

  // parameter access presented to the object store
  typedef struct packed {
    logic write;
    logic [15:0] index;
    logic [7:0] subIndex;
    logic [2:0] size;
    logic [31:0] value;
  } cns_access_type;

  // object store answer
  typedef struct packed {
    logic fail;
    logic [31:0] errCode;
    logic [2:0] size;
    logic [31:0] value;
  } cns_answer_type;

endpackage

// *** cns_node_sdo_access.sv ***
`timescale 1ns/100ps
// Overview of operation
// [R1] node number from switches one to seven
// [R2] switch eight selects controller or driver mode
// [R3] host keeps node number while Operational
// [R4] rate code maps to bus bit rate
// [R5] default rate 500 kbit/s when nothing saved
// [R6] rate only survives reboot when saved
// [R7] only host starts confirmed transfers
// [R8] every accepted command gets a reply
// [R9] host request identifier is 600h plus node
// [R10] reply identifier is 580h plus node
// [R11] lower identifier wins bus contention
// [R12] payload is 1, 2 or 4 bytes
// [R13] message: identifier, length, up to 8 bytes
// [R14] process data unacknowledged, parameter access replied
// [R15] 8, 16, 32-bit integers and 32-bit float supported
// [R16] write commands 2Fh, 2Bh, 23h by size
// [R17] read reply 4Fh/4Bh/43h, write 60h, fail 80h
// [R18] host waits for reply before next request
// [R19] error reply echoes index, carries 4-byte code
// [R20] foreign identifiers ignored, no reply
// [R21] switches and saved rate sampled at reset
module cns_node_sdo_access
  import cns_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // switch bank and stored settings, sampled once after reset
  input wire logic [7:0] switchBank,
  input wire logic rateSaved,
  input wire logic [7:0] savedRateCode,
  // received message
  input wire logic rxValid,
  input wire cns_frame_type rxFrame,
  // reply message toward the bus
  output logic txValid,
  input wire logic txReady,
  output cns_frame_type txFrame,
  // object store port
  output logic accValid,
  output cns_access_type accReq,
  input wire logic ansValid,
  input wire cns_answer_type ansData,
  // configuration seen by the rest of the node
  output logic [6:0] node_number,
  output logic driverMode,
  output logic [10:0] bitRateKbps,
  output logic configDone,
  // process data passed through with no reply
  output logic pdoValid,
  output cns_frame_type pdoFrame
);

  // write command to size code, used by the request decode
  function automatic logic [2:0] wrSize(input logic [7:0] cmd);
    unique case (cmd)
      CMD_WR_1: wrSize = 3'h1;
      CMD_WR_2: wrSize = 3'h2;
      CMD_WR_4: wrSize = 3'h4;
      default: wrSize = 3'h0;
    endcase
  endfunction

  // rate code to kbit/s; an unknown saved code falls back to the default
  function automatic logic [10:0] rateOf(input logic [7:0] code);
    unique case (code)
      RATE_CODE_50K: rateOf = 11'd50;
      RATE_CODE_125K: rateOf = 11'd125;
      RATE_CODE_250K: rateOf = 11'd250;
      RATE_CODE_500K: rateOf = 11'd500;
      RATE_CODE_1M: rateOf = 11'd1000;
      default: rateOf = RATE_KBPS_DEFAULT;
    endcase
  endfunction

  cns_state_type state_q, state_d;
  logic configDone_q;
  logic [6:0] nodeNum_q;
  logic driverMode_q;
  logic [10:0] rate_q;
  cns_frame_type txFrame_q, txFrame_d;
  cns_access_type acc_q;
  logic [7:0] rspCmd;
  logic [3:0] rspLen;
  logic [31:0] rspVal;

  // request decode
  wire logic [10:0] ownReqId = REQ_ID_BASE + {4'h0, nodeNum_q}; // R9
  wire logic [10:0] ownRspId = RSP_ID_BASE + {4'h0, nodeNum_q}; // R10
  wire logic nodeValid = nodeNum_q != 7'h00;
  wire logic idMatch = rxFrame.ident == ownReqId; // R20
  wire logic [7:0] rxCmd = rxFrame.data[0];
  wire logic [2:0] rxWrSize = wrSize(rxCmd); // R16
  wire logic isRead = rxCmd == CMD_RD_REQ;
  wire logic isWrite = rxWrSize != 3'h0;
  // driver mode has no fieldbus role, so requests are dropped there
  wire logic takeReq = rxValid && configDone_q && !driverMode_q && nodeValid && idMatch
    && state_q == ST_IDLE && (isRead || isWrite); // R7 R18 R20
  // a write whose length count disagrees with its command byte is answered with an error
  wire logic lenBad = isWrite && rxFrame.len != 4'(4 + rxWrSize); // R12 R13
  wire logic pdoHit = rxValid && configDone_q && !driverMode_q && !idMatch
    && rxFrame.ident < RSP_ID_BASE; // R14
  wire logic [31:0] rxValue = {rxFrame.data[7], rxFrame.data[6], rxFrame.data[5], rxFrame.data[4]};

  // configuration caught on the first clock after reset release; later switch moves are ignored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      configDone_q <= 1'b0;
      nodeNum_q <= 7'h00;
      driverMode_q <= 1'b0;
      rate_q <= RATE_KBPS_DEFAULT; // R5
    end else if (!configDone_q) begin
      configDone_q <= 1'b1; // R21
      nodeNum_q <= switchBank[6:0]; // R1 R3
      driverMode_q <= switchBank[7]; // R2
      rate_q <= rateSaved ? rateOf(savedRateCode) : RATE_KBPS_DEFAULT; // R4 R6
    end
  end

  // reply byte 0 and payload selection
  always_comb begin
    rspCmd = CMD_WR_ACK;
    rspLen = 4'h4;
    rspVal = 32'h0;
    if (ansData.fail) begin
      rspCmd = CMD_ERROR; // R19
      rspLen = 4'h8;
      rspVal = ansData.errCode;
    end else if (!acc_q.write) begin
      unique case (ansData.size)
        3'h1: rspCmd = CMD_RD_1; // R17
        3'h2: rspCmd = CMD_RD_2;
        3'h4: rspCmd = CMD_RD_4;
        default: rspCmd = CMD_ERROR;
      endcase
      rspLen = 4'(4 + ansData.size);
      rspVal = ansData.value; // R15
      if (rspCmd == CMD_ERROR) begin
        rspLen = 4'h8;
        rspVal = ERR_ACCESS;
      end
    end
  end

  // sequencer: idle, wait for the object store, hold reply until the bus takes it
  always_comb begin
    state_d = state_q;
    txFrame_d = txFrame_q;
    unique case (state_q)
      ST_IDLE: begin
        if (takeReq && lenBad) begin
          state_d = ST_SEND; // R8
          txFrame_d.ident = ownRspId;
          txFrame_d.len = 4'h8;
          txFrame_d.data = {ERR_LEN_MISMATCH[31:24], ERR_LEN_MISMATCH[23:16], ERR_LEN_MISMATCH[15:8],
                            ERR_LEN_MISMATCH[7:0], rxFrame.data[3], rxFrame.data[2], rxFrame.data[1],
                            CMD_ERROR};
        end else if (takeReq) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (ansValid) begin
          state_d = ST_SEND; // R8
          txFrame_d.ident = ownRspId; // R10 R11
          txFrame_d.len = rspLen;
          txFrame_d.data = {rspVal[31:24], rspVal[23:16], rspVal[15:8], rspVal[7:0],
                            acc_q.subIndex, acc_q.index[15:8], acc_q.index[7:0], rspCmd}; // R13 R19
        end
      end
      ST_SEND: begin
        if (txReady) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      txFrame_q <= '0;
    end else begin
      state_q <= state_d;
      txFrame_q <= txFrame_d;
    end
  end

  // access latched on acceptance; valid is a one-cycle pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
      accValid <= 1'b0;
    end else begin
      accValid <= takeReq && !lenBad;
      if (takeReq) begin
        acc_q.write <= isWrite;
        acc_q.index <= {rxFrame.data[2], rxFrame.data[1]};
        acc_q.subIndex <= rxFrame.data[3];
        acc_q.size <= rxWrSize;
        acc_q.value <= rxValue; // R12
      end
    end
  end

  // process data forwarded, never answered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pdoValid <= 1'b0;
      pdoFrame <= '0;
    end else begin
      pdoValid <= pdoHit; // R14
      if (pdoHit) begin
        pdoFrame <= rxFrame;
      end
    end
  end

  assign accReq = acc_q;
  assign txValid = state_q == ST_SEND;
  assign txFrame = txFrame_q;
  assign node_number = nodeNum_q;
  assign driverMode = driverMode_q;
  assign bitRateKbps = rate_q;
  assign configDone = configDone_q;

  // checks
  AST_REPLY_ID: assert property (@(posedge clk) disable iff (!rst_n) // R10
    txValid |-> txFrame.ident == RSP_ID_BASE + {4'h0, node_number})
    else $error("reply identifier wrong");
  AST_FOREIGN_IGNORED: assert property (@(posedge clk) disable iff (!rst_n) // R20
    (state_q == ST_IDLE && rxValid && rxFrame.ident != ownReqId) |=> state_q == ST_IDLE)
    else $error("foreign request taken");
  AST_NO_SPONTANEOUS: assert property (@(posedge clk) disable iff (!rst_n) // R7
    $rose(txValid) |-> $past(ansValid) || $past(takeReq))
    else $error("reply without request");
  AST_ANSWER_REPLIED: assert property (@(posedge clk) disable iff (!rst_n) // R8
    (state_q == ST_WAIT && ansValid) |-> ##RSP_LATENCY_CYC txValid)
    else $error("answer not replied");
  AST_REPLY_HOLDS: assert property (@(posedge clk) disable iff (!rst_n) // R8
    (txValid && !txReady) |=> txValid && $stable(txFrame))
    else $error("reply dropped before taken");
  AST_ERR_CMD: assert property (@(posedge clk) disable iff (!rst_n) // R19
    (state_q == ST_WAIT && ansValid && ansData.fail) |=> txFrame.data[0] == CMD_ERROR && txFrame.len == 4'h8)
    else $error("error reply malformed");
  AST_WRITE_ACK: assert property (@(posedge clk) disable iff (!rst_n) // R17
    (state_q == ST_WAIT && ansValid && !ansData.fail && acc_q.write) |=> txFrame.data[0] == CMD_WR_ACK)
    else $error("write ack wrong");
  AST_NODE_STABLE: assert property (@(posedge clk) disable iff (!rst_n) // R21
    configDone |=> $stable(node_number) && $stable(bitRateKbps))
    else $error("config changed after load");
  AST_NODE_BITS: assert property (@(posedge clk) disable iff (!rst_n) // R1
    $rose(configDone) |-> node_number == $past(switchBank[6:0]) && driverMode == $past(switchBank[7]))
    else $error("switch decode wrong");
  AST_RATE_DEFAULT: assert property (@(posedge clk) disable iff (!rst_n) // R5
    ($rose(configDone) && !$past(rateSaved)) |-> bitRateKbps == RATE_KBPS_DEFAULT)
    else $error("default rate wrong");
  AST_PDO_SILENT: assert property (@(posedge clk) disable iff (!rst_n) // R14
    (pdoHit && state_q == ST_IDLE) |=> !txValid)
    else $error("process data answered");

  // reply contents are checked against the constants, the latched access and the store answer, not against the selection logic
  AST_LEN_ERR_REPLY: assert property (@(posedge clk) disable iff (!rst_n) // R19
    (takeReq && lenBad) |=> txValid && !accValid && txFrame.len == 4'h8
      && txFrame.data[7:4] == ERR_LEN_MISMATCH)
    else $error("length error reply malformed");
  AST_READ_REPLY: assert property (@(posedge clk) disable iff (!rst_n) // R17
    (state_q == ST_WAIT && ansValid && !ansData.fail && !acc_q.write && ansData.size == 3'h4)
      |=> txFrame.data[0] == CMD_RD_4 && txFrame.len == 4'h8 && txFrame.data[7:4] == $past(ansData.value))
    else $error("read reply malformed");
  AST_ECHO: assert property (@(posedge clk) disable iff (!rst_n) // R19
    (state_q == ST_WAIT && ansValid) |=> txFrame.data[3:1] == {$past(acc_q.subIndex), $past(acc_q.index)})
    else $error("index echo wrong");
  AST_ACC_OWN_ID: assert property (@(posedge clk) disable iff (!rst_n) // R20
    accValid |-> $past(rxFrame.ident) == REQ_ID_BASE + {4'h0, node_number})
    else $error("access from foreign identifier");
  AST_ACC_PULSE: assert property (@(posedge clk) disable iff (!rst_n) // R8
    accValid |-> state_q == ST_WAIT ##1 !accValid)
    else $error("access pulse malformed");
  AST_REPLY_TAKEN: assert property (@(posedge clk) disable iff (!rst_n) // R8
    (txValid && txReady) |=> !txValid)
    else $error("reply repeated after take");
  AST_DRIVER_SILENT: assert property (@(posedge clk) disable iff (!rst_n) // R2
    driverMode |-> !accValid && !txValid && !pdoValid)
    else $error("bus activity in driver mode");
  AST_NODE_ZERO_SILENT: assert property (@(posedge clk) disable iff (!rst_n) // R1
    (configDone && node_number == 7'h00) |-> !accValid && !txValid)
    else $error("node zero answered");
  AST_PDO_FROM_RX: assert property (@(posedge clk) disable iff (!rst_n) // R14
    pdoValid |-> $past(rxValid))
    else $error("process data without message");

  // main scenarios
  COV_READ: cover property (@(posedge clk) disable iff (!rst_n) txValid && txFrame.data[0] == CMD_RD_4);
  COV_WRITE: cover property (@(posedge clk) disable iff (!rst_n) txValid && txFrame.data[0] == CMD_WR_ACK);
  COV_ERROR: cover property (@(posedge clk) disable iff (!rst_n) txValid && txFrame.data[0] == CMD_ERROR);
  COV_STALL: cover property (@(posedge clk) disable iff (!rst_n) txValid && !txReady ##1 txValid && txReady);
  COV_PDO: cover property (@(posedge clk) disable iff (!rst_n) pdoValid);

endmodule

// *** cns_obj_store.sv ***
`timescale 1ns/100ps
module cns_obj_store
  import cns_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // access from the front end, wait chosen by the bench
  input wire logic accValid,
  input wire cns_access_type accReq,
  input wire logic [3:0] delay,
  // answer toward the front end
  output logic ansValid,
  output cns_answer_type ansData
);
  logic [31:0] mem [4];
  cns_access_type req;
  logic [3:0] cnt;
  // answers after a chosen wait; index ffff always fails, the low index bits give the object size
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      ansValid <= 1'b0;
      ansData <= '0;
    end else begin
      ansValid <= 1'b0;
      ansData <= ~ansData; // stale answer must not look usable
      if (accValid) begin
        req <= accReq;
        cnt <= delay + 4'h1;
      end else if (cnt == 4'h1) begin
        cnt <= 4'h0;
        ansValid <= 1'b1;
        ansData.fail <= (req.index == 16'hffff);
        ansData.errCode <= 32'h06090030;
        ansData.size <= req.index[2:0];
        ansData.value <= mem[req.subIndex[1:0]];
        if (req.write) mem[req.subIndex[1:0]] <= req.value;
      end else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    end
  end
endmodule

// *** testbench.sv ***
`timescale 1ns/100ps
`define CHK(a, e, nm) begin n_checks++; if ((a) !== (e)) begin errors++; $display("unexpected %s: expected %h seen %h", nm, e, a); end end
module testbench
  import cns_pkg::*;
;
  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] idx;
    logic [7:0] sub;
    logic [3:0] len;
    logic [31:0] val;
    logic [3:0] dly;
    logic [3:0] stall;
    logic [7:0] ecmd;
    logic [3:0] elen;
    logic [31:0] eval;
  } cns_tb_row_type;
  logic clk, rst_n, rateSaved, rxValid, txValid, txReady, accValid, ansValid;
  logic driverMode, configDone, pdoValid, got, pv;
  logic [7:0] switchBank, savedRateCode;
  logic [3:0] delay;
  logic [6:0] node_number;
  logic [10:0] bitRateKbps;
  cns_frame_type rxFrame, txFrame, pdoFrame, rsp;
  cns_access_type accReq;
  cns_answer_type ansData;
  int errors = 0;
  int n_checks = 0;
  // writes of each size, reads back, then store failure, length mismatch and unsupported read size
  cns_tb_row_type rows [9] = '{
    '{CMD_WR_1, 16'h2001, 8'h00, 4'h5, 32'h000000ef, 4'h0, 4'h0, CMD_WR_ACK, 4'h4, 32'h0},
    '{CMD_WR_2, 16'h2002, 8'h01, 4'h6, 32'h000003e8, 4'h5, 4'h3, CMD_WR_ACK, 4'h4, 32'h0},
    '{CMD_WR_4, 16'h2004, 8'h02, 4'h8, 32'h12345678, 4'h0, 4'h0, CMD_WR_ACK, 4'h4, 32'h0},
    '{CMD_RD_REQ, 16'h2001, 8'h00, 4'h4, 32'h0, 4'h2, 4'h0, CMD_RD_1, 4'h5, 32'h000000ef},
    '{CMD_RD_REQ, 16'h2002, 8'h01, 4'h4, 32'h0, 4'h0, 4'h4, CMD_RD_2, 4'h6, 32'h000003e8},
    '{CMD_RD_REQ, 16'h2004, 8'h02, 4'h4, 32'h0, 4'h7, 4'h0, CMD_RD_4, 4'h8, 32'h12345678},
    '{CMD_WR_4, 16'hffff, 8'h00, 4'h8, 32'h00000001, 4'h0, 4'h1, CMD_ERROR, 4'h8, 32'h06090030},
    '{CMD_WR_2, 16'h2002, 8'h01, 4'h8, 32'h00000001, 4'h0, 4'h0, CMD_ERROR, 4'h8, 32'h06070010},
    '{CMD_RD_REQ, 16'h2003, 8'h00, 4'h4, 32'h0, 4'h0, 4'h0, CMD_ERROR, 4'h8, 32'h06010000}};
  logic [7:0] codes [5] = '{RATE_CODE_50K, RATE_CODE_125K, RATE_CODE_250K, RATE_CODE_500K, RATE_CODE_1M};
  logic [10:0] kbps [5] = '{11'h032, 11'h07d, 11'h0fa, 11'h1f4, 11'h3e8};

  cns_node_sdo_access cns_node_sdo_access_i (.clk(clk), .rst_n(rst_n), .switchBank(switchBank),
    .rateSaved(rateSaved), .savedRateCode(savedRateCode), .rxValid(rxValid), .rxFrame(rxFrame),
    .txValid(txValid), .txReady(txReady), .txFrame(txFrame), .accValid(accValid), .accReq(accReq),
    .ansValid(ansValid), .ansData(ansData), .node_number(node_number), .driverMode(driverMode),
    .bitRateKbps(bitRateKbps), .configDone(configDone), .pdoValid(pdoValid), .pdoFrame(pdoFrame));
  cns_obj_store cns_obj_store_i (.clk(clk), .rst_n(rst_n), .accValid(accValid), .accReq(accReq),
    .delay(delay), .ansValid(ansValid), .ansData(ansData));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // only bytes below the length count carry meaning
  function automatic logic [31:0] lmask(input logic [3:0] l);
    return (l >= 4'h8) ? 32'hffffffff : (l == 4'h6) ? 32'h0000ffff : (l == 4'h5) ? 32'h000000ff : 32'h0;
  endfunction

  task automatic final_report();
    if (errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // reset with new switch and rate settings; config is only taken at reset
  task automatic do_reset(input logic [7:0] sw, input logic saved, input logic [7:0] code);
    rst_n = 1'b0;
    switchBank = sw;
    rateSaved = saved;
    savedRateCode = code;
    repeat (3) @(negedge clk);
    `CHK(bitRateKbps, RATE_KBPS_DEFAULT, "rate in reset")
    `CHK(configDone, 1'b0, "configDone in reset")
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    `CHK(configDone, 1'b1, "configDone")
  endtask

  // one request at a time: the next is sent after the reply was taken, or after 40 cycles with no reply
  task automatic req(input logic [10:0] id, input cns_tb_row_type r);
    int i;
    @(negedge clk);
    rxFrame = '{ident: id, len: r.len, data: {r.val, r.sub, r.idx, r.cmd}};
    delay = r.dly;
    rxValid = 1'b1;
    @(negedge clk);
    rxValid = 1'b0;
    pv = pdoValid;
    got = 1'b0;
    for (i = 0; i < 40 && !got; i++) begin
      if (txValid === 1'b1) got = 1'b1;
      else @(negedge clk);
    end
    if (got) begin
      repeat (r.stall) @(negedge clk);
      `CHK(txValid, 1'b1, "txValid held")
      rsp = txFrame;
      txReady = 1'b1;
      @(negedge clk);
      txReady = 1'b0;
      `CHK(txValid, 1'b0, "txValid after take")
    end
  endtask

  // watchdog far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    errors++;
    final_report();
  end

  initial begin
    rxValid = 1'b0;
    txReady = 1'b0;
    delay = 4'h0;
    rxFrame = '0;
    do_reset(8'h69, 1'b0, 8'h00);
    `CHK(node_number, 7'h69, "node number")
    `CHK(driverMode, 1'b0, "driverMode")
    `CHK(txValid, 1'b0, "no spontaneous reply")
    foreach (rows[k]) begin
      req(REQ_ID_BASE + 11'h069, rows[k]);
      `CHK(got, 1'b1, "reply seen")
      `CHK(pv, 1'b0, "pdo on request")
      `CHK(rsp.ident, RSP_ID_BASE + 11'h069, "reply ident")
      `CHK(rsp.data[0], rows[k].ecmd, "reply command")
      `CHK(rsp.len, rows[k].elen, "reply length")
      `CHK(rsp.data[3:1], {rows[k].sub, rows[k].idx}, "echo")
      `CHK(rsp.data[7:4] & lmask(rows[k].elen), rows[k].eval, "reply value")
    end
    req(REQ_ID_BASE + 11'h068, rows[3]);
    `CHK(got, 1'b0, "foreign ident")
    req(11'h181, rows[0]);
    `CHK(got, 1'b0, "pdo reply")
    `CHK(pv, 1'b1, "pdo forwarded")
    `CHK(pdoFrame.ident, 11'h181, "pdo ident")
    `CHK(pdoFrame.data[3:0], {rows[0].sub, rows[0].idx, rows[0].cmd}, "pdo bytes")
    switchBank = 8'h7f;
    repeat (3) @(negedge clk);
    `CHK(node_number, 7'h69, "node frozen")
    do_reset(8'h7f, 1'b1, 8'h07);
    `CHK(node_number, 7'h7f, "node 127")
    `CHK(bitRateKbps, RATE_KBPS_DEFAULT, "unknown code")
    foreach (codes[k]) begin
      do_reset(8'h01, 1'b1, codes[k]);
      `CHK(bitRateKbps, kbps[k], "rate")
    end
    do_reset(8'h01, 1'b0, RATE_CODE_1M);
    `CHK(bitRateKbps, RATE_KBPS_DEFAULT, "unsaved rate")
    do_reset(8'h00, 1'b0, 8'h00);
    req(REQ_ID_BASE, rows[3]);
    `CHK(got, 1'b0, "node zero request")
    do_reset(8'he9, 1'b0, 8'h00);
    `CHK(driverMode, 1'b1, "driver mode")
    req(REQ_ID_BASE + 11'h069, rows[3]);
    `CHK(got, 1'b0, "driver mode request")
    final_report();
  end
endmodule
